// *** rtl/sofmt_defines.vh ***
// Shared register map, field positions and codes of the SPI output formatter
`ifndef SOFMT_DEFINES_VH
`define SOFMT_DEFINES_VH

// Register word indices; byte address is four times the index
`define SOFMT_IDX_OUT_CONFIG   8'h04
`define SOFMT_IDX_POLL_STATUS  8'h6c
`define SOFMT_IDX_POLL_MERGED  8'h6d
`define SOFMT_IDX_CURRENTS     8'h70
`define SOFMT_IDX_DAC_ADDR     8'h71
`define SOFMT_IDX_COVER_DATA   8'h72
`define SOFMT_IDX_POLL_CMD     8'h73
`define SOFMT_ADDR_W           10

// Output config fields
`define SOFMT_FMT_LSB          0
`define SOFMT_FMT_MSB          3
`define SOFMT_POLL_OFF_BIT     5
`define SOFMT_LEN_LSB          8
`define SOFMT_LEN_MSB          13
`define SOFMT_DIV_LSB          16
`define SOFMT_DIV_MSB          23
`define SOFMT_CONFIG_RESET     32'h0000_2800

// Format codes
`define SOFMT_FMT_OFF          4'h0
`define SOFMT_FMT_DAC_OFFSET   4'h1
`define SOFMT_FMT_DAC_ABS_POS1 4'h2
`define SOFMT_FMT_DAC_ABS_POS0 4'h3
`define SOFMT_FMT_SCALE        4'h4
`define SOFMT_FMT_SIGNED       4'h5
`define SOFMT_FMT_DAC_SCALE    4'h6
`define SOFMT_FMT_COVER_ONLY   4'hf

// Payload constants
`define SOFMT_SCALE_BITS       6'h08
`define SOFMT_SIGNED_BITS      6'h12
`define SOFMT_OFFSET_MID       9'h080
`define SOFMT_DAT_W            40
`define SOFMT_POLL_PERIOD      16'h4000

`endif

// *** rtl/sofmt_skid.v ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sofmt_skid #(
   parameter W = 46
) (
   input  wire         clk,
   input  wire         rstn,
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);
   reg [W-1:0] mem [0:1];
   reg         wr_ptr;
   reg         rd_ptr;
   reg [1:0]   count;
   wire        push;
   wire        pop;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and fill level; simultaneous push and pop keep count
   always @(posedge clk) begin
      if (!rstn) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push & ~pop)
            count <= count + 2'h1;
         else if (pop & ~push)
            count <= count - 2'h1;
      end
   end
endmodule
`default_nettype wire

// *** rtl/sofmt_shifter.v ***
// Serial engine: one chip-select frame of a given bit count, MSB first
`timescale 1ns/1ps
`default_nettype none
module sofmt_shifter #(
   parameter DW = 40
) (
   input  wire          clk,
   input  wire          rstn,
   input  wire [DW-1:0] tx_data,
   input  wire [5:0]    tx_len,
   input  wire [7:0]    half_div,
   input  wire          start,
   output reg           busy,
   output reg           done,
   output reg  [DW-1:0] rx_data,
   output reg           sck,
   output reg           mosi,
   output reg           cs_n,
   input  wire          miso_sync
);
   reg [DW-1:0] shreg;
   reg [5:0]    bits_left;
   reg [7:0]    div_cnt;

   // Falling edge shifts out, rising edge samples; idle clock high
   always @(posedge clk) begin
      if (!rstn) begin
         busy      <= 1'b0;
         done      <= 1'b0;
         rx_data   <= {DW{1'b0}};
         sck       <= 1'b1;
         mosi      <= 1'b0;
         cs_n      <= 1'b1;
         shreg     <= {DW{1'b0}};
         bits_left <= 6'h00;
         div_cnt   <= 8'h00;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            if (start) begin
               busy      <= 1'b1;
               cs_n      <= 1'b0;                    // [R17]
               shreg     <= tx_data << (DW - tx_len);
               bits_left <= tx_len;
               div_cnt   <= half_div;
            end
         end else if (div_cnt != 8'h00) begin
            div_cnt <= div_cnt - 8'h01;
         end else begin
            div_cnt <= half_div;
            if (sck) begin
               if (bits_left == 6'h00) begin
                  cs_n    <= 1'b1;                   // [R17]
                  busy    <= 1'b0;
                  done    <= 1'b1;
                  rx_data <= shreg;
               end else begin
                  sck       <= 1'b0;
                  mosi      <= shreg[DW-1];
                  bits_left <= bits_left - 6'h01;
               end
            end else begin
               sck   <= 1'b1;
               shreg <= {shreg[DW-2:0], miso_sync};
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/sofmt_top.v ***
// SPI output formatter: register file, payload builder, polling, sign pins
//
// Contract
// [R1] Polling runs and stores results only while polling-disable bit 5 is zero.
// [R2] Polled driver status word is copied to readable register 0x6c.
// [R3] Global flags, PWM scale, lost-step replies merge into register 0x6d.
// [R4] Format 0000 switches SPI output pins off.
// [R5] Format 1111 sends only software datagrams; value changes send nothing. The code also sends polling datagrams in 1111 while bit 5 is zero.
// [R6] Configuration-only mode uses native driver framing only.
// [R7] Format 0100 sends scale factor bits 7:0, MSB first, on change.
// [R8] Scale payload longer than 8 bits gets leading zeros.
// [R9] Format 0101 sends coil A 17:9 and coil B 8:0 in one datagram.
// [R10] Signed payload sends bit 17 first, leading zeros when longer.
// [R11] Format 0110 sends scale value tagged with configured DAC address.
// [R12] Format 0011 sends two addressed magnitudes; sign pins 0 means positive.
// [R13] Format 0010 like 0011 but sign 1 means positive.
// [R14] Format 0001 offset-maps currents: -255 to 0, 0 to 128, 255 to 255.
// [R15] Software sets datagram length to what the driver expects.
// [R16] Coil B datagram follows automatically when coil A completes.
// [R17] One chip-select assertion spans exactly the configured clock periods.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sofmt_defines.vh"
module sofmt_top #(
   parameter DW          = `SOFMT_DAT_W,
   parameter POLL_PERIOD = `SOFMT_POLL_PERIOD
) (
   input  wire                    clk,
   input  wire                    rstn,
   input  wire [`SOFMT_ADDR_W-1:0] addr,
   input  wire [31:0]             wdata,
   input  wire                    wr,
   input  wire                    rd,
   output reg  [31:0]             rdata,
   input  wire [7:0]              current_scale_factor,
   input  wire [8:0]              coil_a_current,
   input  wire [8:0]              coil_b_current,
   output reg                     spi_sck,
   output reg                     spi_sck_oe,
   output reg                     spi_mosi,
   output reg                     spi_mosi_oe,
   output reg                     spi_cs_n,
   output reg                     spi_cs_n_oe,
   input  wire                    spi_miso,
   output reg                     step_output_pin,
   output reg                     direction_output_pin
);
   // Job kinds travelling through the buffer
   localparam K_COVER = 2'h0;
   localparam K_POLL  = 2'h1;
   localparam K_DATA  = 2'h2;
   localparam JW      = DW + 6 + 2;

   // Sequencer states, one-hot
   localparam S_IDLE  = 3'b001;
   localparam S_SEND  = 3'b010;
   localparam S_WAIT  = 3'b100;

   reg  [31:0]   spi_output_config;
   reg  [31:0]   polled_driver_status;
   reg  [31:0]   polled_merged_regs;
   reg  [31:0]   dac_addr_cfg;
   reg  [31:0]   cover_data;
   reg  [31:0]   poll_cmd;
   reg  [7:0]    last_scale;
   reg  [8:0]    last_a;
   reg  [8:0]    last_b;
   reg           pend_b;
   reg  [15:0]   poll_cnt;
   reg  [1:0]    poll_sel;
   reg  [2:0]    state;
   reg  [1:0]    cur_kind;
   reg  [1:0]    cur_poll;
   reg           miso_meta;
   reg           miso_sync;
   reg  [JW-1:0] next_job;
   reg           next_valid;
   reg           cover_req;
   reg           poll_req;

   wire [3:0]    fmt = spi_output_config[`SOFMT_FMT_MSB:`SOFMT_FMT_LSB];
   wire          poll_off = spi_output_config[`SOFMT_POLL_OFF_BIT];
   wire [5:0]    cfg_len = spi_output_config[`SOFMT_LEN_MSB:`SOFMT_LEN_LSB];
   wire [7:0]    half_div = spi_output_config[`SOFMT_DIV_MSB:`SOFMT_DIV_LSB];
   wire          dac_mode = (fmt == `SOFMT_FMT_DAC_OFFSET) |
                            (fmt == `SOFMT_FMT_DAC_ABS_POS1) |
                            (fmt == `SOFMT_FMT_DAC_ABS_POS0);
   wire          native = (fmt == `SOFMT_FMT_COVER_ONLY);
   wire          in_ready;
   wire [JW-1:0] buf_job;
   wire          buf_valid;
   wire          buf_ready = state[1];
   wire          sh_busy;
   wire          sh_done;
   wire [DW-1:0] sh_rx;
   wire          sh_sck;
   wire          sh_mosi;
   wire          sh_cs_n;
   wire          scale_chg = (current_scale_factor != last_scale);
   wire          cur_chg = (coil_a_current != last_a) | (coil_b_current != last_b);

   // Word index from byte address, bus is word aligned
   function [7:0] reg_idx;
      input [`SOFMT_ADDR_W-1:0] a;
      begin
         reg_idx = a[`SOFMT_ADDR_W-1:2];
      end
   endfunction

   // Magnitude of a 9-bit signed current
   function [7:0] mag;
      input [8:0] c;
      begin
         mag = c[8] ? (8'h00 - c[7:0]) : c[7:0];
      end
   endfunction

   // DAC value for one coil, by format
   function [7:0] dac_val;
      input [3:0] f;
      input [8:0] c;
      reg   [8:0] sum;
      begin
         sum = 9'h000;
         if (f == `SOFMT_FMT_DAC_OFFSET) begin
            // Halve then bias so -255..255 spans 0..255
            sum = {c[8], c[8:1]} + `SOFMT_OFFSET_MID;  // [R14]
            dac_val = sum[7:0];
         end else begin
            dac_val = mag(c);                         // [R12] [R13]
         end
      end
   endfunction

   // Input synchroniser for the returning serial data
   always @(posedge clk) begin
      if (!rstn) begin
         miso_meta <= 1'b0;
         miso_sync <= 1'b0;
      end else begin
         miso_meta <= spi_miso;
         miso_sync <= miso_meta;
      end
   end

   // Job selection: cover first, then payload, then coil B, then coil A, then polling
   always @* begin
      next_job   = {JW{1'b0}};
      next_valid = 1'b0;
      if (cover_req) begin
         next_job   = {K_COVER, cfg_len, {(DW-32){1'b0}}, cover_data};  // [R5] [R6]
         next_valid = 1'b1;
      end else if (fmt == `SOFMT_FMT_SCALE && scale_chg) begin
         // Zero-extended so extra length shifts zeros out first
         next_job   = {K_DATA, cfg_len, {(DW-8){1'b0}}, current_scale_factor};  // [R7] [R8]
         next_valid = 1'b1;
      end else if (fmt == `SOFMT_FMT_SIGNED && cur_chg) begin
         next_job   = {K_DATA, cfg_len, {(DW-18){1'b0}}, coil_a_current,
                       coil_b_current};                         // [R9] [R10]
         next_valid = 1'b1;
      end else if (fmt == `SOFMT_FMT_DAC_SCALE && scale_chg) begin
         next_job   = {K_DATA, cfg_len, {(DW-16){1'b0}}, dac_addr_cfg[7:0],
                       current_scale_factor};                   // [R11]
         next_valid = 1'b1;
      end else if (pend_b) begin
         next_job   = {K_DATA, cfg_len, {(DW-16){1'b0}}, dac_addr_cfg[15:8],
                       dac_val(fmt, last_b)};                   // [R16]
         next_valid = 1'b1;
      end else if (dac_mode && cur_chg) begin
         next_job   = {K_DATA, cfg_len, {(DW-16){1'b0}}, dac_addr_cfg[7:0],
                       dac_val(fmt, coil_a_current)};           // [R12]
         next_valid = 1'b1;
      end else if (poll_req) begin
         next_job   = {K_POLL, cfg_len, {(DW-32){1'b0}}, poll_cmd[7:0], 24'h000000};
         next_valid = 1'b1;
      end
   end

   sofmt_skid #(
      .W (JW)
   ) u_skid (
      .clk       (clk),
      .rstn      (rstn),
      .in_data   (next_job),
      .in_valid  (next_valid),
      .in_ready  (in_ready),
      .out_data  (buf_job),
      .out_valid (buf_valid),
      .out_ready (buf_ready)
   );

   sofmt_shifter #(
      .DW (DW)
   ) u_shifter (
      .clk       (clk),
      .rstn      (rstn),
      .tx_data   (buf_job[DW-1:0]),
      .tx_len    (buf_job[DW+5:DW]),
      .half_div  (half_div),
      .start     (state[1] & ~(poll_off && cur_kind == K_POLL)),
      .busy      (sh_busy),
      .done      (sh_done),
      .rx_data   (sh_rx),
      .sck       (sh_sck),
      .mosi      (sh_mosi),
      .cs_n      (sh_cs_n),
      .miso_sync (miso_sync)
   );

   // Register writes, change tracking, polling timer
   always @(posedge clk) begin
      if (!rstn) begin
         spi_output_config <= `SOFMT_CONFIG_RESET;
         dac_addr_cfg      <= 32'h0000_0000;
         cover_data        <= 32'h0000_0000;
         poll_cmd          <= 32'h0000_0000;
         cover_req         <= 1'b0;
         last_scale        <= 8'h00;
         last_a            <= 9'h000;
         last_b            <= 9'h000;
         pend_b            <= 1'b0;
         poll_cnt          <= 16'h0000;
         poll_req          <= 1'b0;
      end else begin
         if (wr && reg_idx(addr) == `SOFMT_IDX_OUT_CONFIG)
            spi_output_config <= wdata;
         else if (wr && reg_idx(addr) == `SOFMT_IDX_DAC_ADDR)
            dac_addr_cfg <= wdata;
         else if (wr && reg_idx(addr) == `SOFMT_IDX_POLL_CMD)
            poll_cmd <= wdata;
         // A new cover write wins over the consume of an older one
         if (wr && reg_idx(addr) == `SOFMT_IDX_COVER_DATA && fmt != `SOFMT_FMT_OFF) begin
            cover_data <= wdata;
            cover_req  <= 1'b1;
         end else if (in_ready && cover_req) begin
            cover_req <= 1'b0;
         end
         // In payload formats, values latched only when a datagram is queued
         if (in_ready && next_valid && next_job[JW-1:JW-2] == K_DATA) begin
            if (pend_b && !(fmt == `SOFMT_FMT_SCALE || fmt == `SOFMT_FMT_SIGNED ||
                            fmt == `SOFMT_FMT_DAC_SCALE)) begin
               pend_b <= 1'b0;                                  // [R16]
            end else begin
               last_scale <= current_scale_factor;
               last_a     <= coil_a_current;
               last_b     <= coil_b_current;
               pend_b     <= dac_mode;
            end
         end else if (!(fmt == `SOFMT_FMT_SCALE || fmt == `SOFMT_FMT_SIGNED ||
                        fmt == `SOFMT_FMT_DAC_SCALE || dac_mode)) begin
            // Idle formats track silently so nothing fires on switch
            last_scale <= current_scale_factor;                 // [R5]
            last_a     <= coil_a_current;
            last_b     <= coil_b_current;
            pend_b     <= 1'b0;
         end
         // Polling timer, cleared while disabled or output off
         if (poll_off || fmt == `SOFMT_FMT_OFF) begin
            poll_cnt <= 16'h0000;                               // [R1]
            poll_req <= 1'b0;
         end else if (poll_req) begin
            if (in_ready && !cover_req && !next_job[JW-1] && next_job[JW-2])
               poll_req <= 1'b0;
         end else if (poll_cnt == POLL_PERIOD - 1) begin
            poll_cnt <= 16'h0000;
            poll_req <= 1'b1;
         end else begin
            poll_cnt <= poll_cnt + 16'h0001;
         end
      end
   end

   // Sequencer: hand one buffered job to the shifter and wait for it
   always @(posedge clk) begin
      if (!rstn) begin
         state                <= S_IDLE;
         cur_kind             <= K_COVER;
         cur_poll             <= 2'h0;
         poll_sel             <= 2'h0;
         polled_driver_status <= 32'h0000_0000;
         polled_merged_regs   <= 32'h0000_0000;
      end else begin
         case (state)
            S_IDLE: begin
               if (buf_valid) begin
                  cur_kind <= buf_job[JW-1:JW-2];
                  cur_poll <= poll_sel;
                  state    <= S_SEND;
               end
            end
            S_SEND: begin
               state <= (poll_off && cur_kind == K_POLL) ? S_IDLE : S_WAIT;  // [R1]
            end
            S_WAIT: begin
               if (sh_done) begin
                  state <= S_IDLE;
                  if (cur_kind == K_POLL && !poll_off) begin
                     poll_sel <= poll_sel + 2'h1;
                     case (cur_poll)
                        2'h0: polled_driver_status <= sh_rx[31:0];          // [R1] [R2]
                        2'h1: polled_merged_regs[7:0] <= sh_rx[7:0];        // [R3]
                        2'h2: polled_merged_regs[15:8] <= sh_rx[7:0];       // [R3]
                        default: polled_merged_regs[31:16] <= sh_rx[15:0];  // [R3]
                     endcase
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clk) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         if (reg_idx(addr) == `SOFMT_IDX_OUT_CONFIG)
            rdata <= spi_output_config;
         else if (reg_idx(addr) == `SOFMT_IDX_POLL_STATUS)
            rdata <= polled_driver_status;                      // [R2]
         else if (reg_idx(addr) == `SOFMT_IDX_POLL_MERGED)
            rdata <= polled_merged_regs;                        // [R3]
         else if (reg_idx(addr) == `SOFMT_IDX_DAC_ADDR)
            rdata <= dac_addr_cfg;
         else if (reg_idx(addr) == `SOFMT_IDX_COVER_DATA)
            rdata <= cover_data;
         else if (reg_idx(addr) == `SOFMT_IDX_POLL_CMD)
            rdata <= poll_cmd;
         else if (reg_idx(addr) == `SOFMT_IDX_CURRENTS)
            rdata <= {6'h00, coil_a_current, coil_b_current, current_scale_factor};
         else
            rdata <= 32'h0000_0000;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // Pin stage: registered copies, enables low when output is off
   always @(posedge clk) begin
      if (!rstn) begin
         spi_sck              <= 1'b1;
         spi_mosi             <= 1'b0;
         spi_cs_n             <= 1'b1;
         spi_sck_oe           <= 1'b0;
         spi_mosi_oe          <= 1'b0;
         spi_cs_n_oe          <= 1'b0;
         step_output_pin      <= 1'b0;
         direction_output_pin <= 1'b0;
      end else begin
         spi_sck     <= sh_sck;
         spi_mosi    <= sh_mosi;
         spi_cs_n    <= sh_cs_n;
         spi_sck_oe  <= (fmt != `SOFMT_FMT_OFF);                // [R4]
         spi_mosi_oe <= (fmt != `SOFMT_FMT_OFF);                // [R4]
         spi_cs_n_oe <= (fmt != `SOFMT_FMT_OFF) | native;       // [R4]
         // Sign of each coil on the step/direction pins
         if (fmt == `SOFMT_FMT_DAC_ABS_POS0) begin
            step_output_pin      <= coil_a_current[8];          // [R12]
            direction_output_pin <= coil_b_current[8];
         end else if (fmt == `SOFMT_FMT_DAC_ABS_POS1) begin
            step_output_pin      <= ~coil_a_current[8];         // [R13]
            direction_output_pin <= ~coil_b_current[8];
         end else begin
            step_output_pin      <= 1'b0;
            direction_output_pin <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/sofmt_top_checker.sv ***
// Port-level assertions for the SPI output formatter
`timescale 1ns/1ps
`default_nettype none
`include "sofmt_defines.vh"
module sofmt_top_checker (
   input wire logic                     clk,
   input wire logic                     rstn,
   input wire logic [`SOFMT_ADDR_W-1:0] addr,
   input wire logic [31:0]              wdata,
   input wire logic                     wr,
   input wire logic                     rd,
   input wire logic [31:0]              rdata,
   input wire logic [8:0]               coil_a_current,
   input wire logic [8:0]               coil_b_current,
   input wire logic                     spi_sck,
   input wire logic                     spi_sck_oe,
   input wire logic                     spi_mosi_oe,
   input wire logic                     spi_cs_n,
   input wire logic                     spi_cs_n_oe,
   input wire logic                     step_output_pin,
   input wire logic                     direction_output_pin
);
   logic [31:0] cfg;
   logic        cov;
   logic [5:0]  nr;
   wire  [3:0]  fmt = cfg[3:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Shadow config, pending software datagram, sck rises within a frame
   always @(posedge clk) begin
      if (!rstn) begin
         cfg <= `SOFMT_CONFIG_RESET;
         cov <= 1'b0;
         nr  <= 6'h00;
      end else begin
         if (wr && addr == 10'h010) cfg <= wdata;
         if (wr && addr == 10'h1c8) cov <= 1'b1;
         else if ($fell(spi_cs_n)) cov <= 1'b0;
         if (spi_cs_n) nr <= 6'h00;
         else if ($rose(spi_sck)) nr <= nr + 6'h01;
      end
   end
   property p_off; (fmt == 4'h0)[*4] |-> !(spi_sck_oe | spi_mosi_oe | spi_cs_n_oe); endproperty
   a_off: assert property (p_off) else $error("Serial pins driven while off");
   property p_len; $rose(spi_cs_n) |-> nr == cfg[13:8]; endproperty
   a_len: assert property (p_len) else $error("Frame clock count wrong");
   property p_sck; $changed(spi_sck) |-> !spi_cs_n; endproperty
   a_sck: assert property (p_sck) else $error("Serial clock moved outside frame");
   property p_end; $rose(spi_cs_n) |-> spi_sck; endproperty
   a_end: assert property (p_end) else $error("Frame closed with clock low");
   property p_cov; $fell(spi_cs_n) && fmt == 4'hf && $past(cfg[5], 2) |-> cov; endproperty
   a_cov: assert property (p_cov) else $error("Unrequested frame in cover mode");
   property p_pos0;
      (fmt == 4'h3 && $stable(coil_a_current) && $stable(coil_b_current))[*3]
      |-> step_output_pin == coil_a_current[8] && direction_output_pin == coil_b_current[8];
   endproperty
   a_pos0: assert property (p_pos0) else $error("Sign pins wrong, zero-positive");
   property p_pos1;
      (fmt == 4'h2 && $stable(coil_a_current) && $stable(coil_b_current))[*3]
      |-> step_output_pin != coil_a_current[8] && direction_output_pin != coil_b_current[8];
   endproperty
   a_pos1: assert property (p_pos1) else $error("Sign pins wrong, one-positive");
   property p_nosign;
      (fmt != 4'h2 && fmt != 4'h3)[*3] |-> !step_output_pin && !direction_output_pin;
   endproperty
   a_nosign: assert property (p_nosign) else $error("Sign pins set outside DAC");
   property p_rd; !$past(rd) |-> rdata == 32'h0; endproperty
   a_rd: assert property (p_rd) else $error("Read data outside read slot");
endmodule
bind sofmt_top sofmt_top_checker u_chk (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .coil_a_current(coil_a_current), .coil_b_current(coil_b_current),
   .spi_sck(spi_sck), .spi_sck_oe(spi_sck_oe), .spi_mosi_oe(spi_mosi_oe),
   .spi_cs_n(spi_cs_n), .spi_cs_n_oe(spi_cs_n_oe),
   .step_output_pin(step_output_pin), .direction_output_pin(direction_output_pin));
`default_nettype wire

// *** tb/sofmt_drv_model.sv ***
// Behavioural driver chip on the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module sofmt_drv_model #(
   parameter logic [31:0] REPLY = 32'ha5c3_0f96
) (
   input  wire logic clk,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic mosi,
   output var  logic miso
);
   logic [39:0] sh, word, prev;
   logic [31:0] tx;
   int          bits, n = 0, frames = 0;
   initial miso = 1'b0;
   // Sample on the rising clock, as the driver does
   always @(posedge sck) if (!cs_n) begin
      sh <= {sh[38:0], mosi};
      n  <= n + 1;
   end
   // Frame closes; a startup edge with no bits is not a frame
   always @(posedge cs_n) if (n != 0) begin
      prev   <= word;
      word   <= sh;
      bits   <= n;
      frames <= frames + 1;
   end
   always @(negedge cs_n) begin
      sh <= '0;
      n  <= 0;
      tx <= REPLY;
   end
   // Reply MSB first, moved on the falling clock
   always @(negedge sck) if (!cs_n) begin
      miso <= tx[31];
      tx   <= {tx[30:0], 1'b0};
   end
   // Released line: toggle so a stale bit cannot pass
   always @(posedge clk) if (cs_n) miso <= ~miso;
endmodule
`default_nettype wire

// *** tb/spi_output_formatter_test.sv ***
// Self-checking bench for the SPI output formatter
`timescale 1ns/1ps
`default_nettype none
`include "sofmt_defines.vh"
module spi_output_formatter_test;
   localparam logic [9:0] CFG = 10'h010, STS = 10'h1b0, DAC = 10'h1c4, COV = 10'h1c8;
   logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [9:0]  addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [7:0]  scl = '0;
   logic [8:0]  ca = '0, cb = '0;
   logic        sck, sck_oe, mosi, mosi_oe, cs_n, cs_oe, miso, stp, dir;
   logic [3:0]  fm [3] = '{4'h3, 4'h2, 4'h1};
   logic [1:0]  ep [3] = '{2'b10, 2'b01, 2'b00};
   logic [7:0]  ea [3] = '{8'hff, 8'hff, 8'h00};
   logic [7:0]  eb [3] = '{8'h00, 8'h00, 8'h80};
   int          n_fail = 0, tests_run = 0, n0 = 0;
   always #2 clk = ~clk;
   sofmt_top #(.POLL_PERIOD(64)) dut (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .current_scale_factor(scl), .coil_a_current(ca), .coil_b_current(cb),
      .spi_sck(sck), .spi_sck_oe(sck_oe), .spi_mosi(mosi), .spi_mosi_oe(mosi_oe),
      .spi_cs_n(cs_n), .spi_cs_n_oe(cs_oe), .spi_miso(miso),
      .step_output_pin(stp), .direction_output_pin(dir));
   sofmt_drv_model p (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   task chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   task wreg(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rreg(input logic [9:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // Format, length, polling off; divider 3 leaves the miso synchroniser room
   task cfg(input logic [3:0] f, input logic [5:0] len, input logic off);
      wreg(CFG, {16'h0003, 2'b0, len, 2'b0, off, 1'b0, f});
      repeat (400) @(posedge clk);
      n0 = p.frames;
   endtask
   // Wait for k frames, then linger so an extra frame is caught too
   task waitf(input int k);
      for (int i = 0; i < 4000 && p.frames < n0 + k; i++) @(posedge clk);
      repeat (300) @(posedge clk);
      chk(40'(p.frames), 40'(n0 + k));
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rreg(CFG, `SOFMT_CONFIG_RESET);
      rreg(10'h3fc, 32'h0);
      wreg(COV, 32'h5a);
      waitf(0);
      chk({cs_oe, sck_oe, mosi_oe}, 40'h0);
      $display("output off done");
      cfg(4'hf, 6'd8, 1'b1);
      wreg(COV, 32'h5a);
      waitf(1);
      chk(p.word, 40'h5a);
      chk(40'(p.bits), 40'd8);
      n0  = p.frames;
      scl <= 8'h33;
      waitf(0);
      $display("cover only done");
      cfg(4'h4, 6'd12, 1'b1);
      scl <= 8'hc5;
      waitf(1);
      chk(p.word, 40'h0c5);
      cfg(4'h5, 6'd20, 1'b1);
      ca <= 9'h1f3;
      cb <= 9'h07e;
      waitf(1);
      chk(p.word, {22'h0, 9'h1f3, 9'h07e});
      chk(40'(p.bits), 40'd20);
      wreg(DAC, 32'h0000_9c4b);
      cfg(4'h6, 6'd16, 1'b1);
      scl <= 8'h5e;
      waitf(1);
      chk(p.word, 40'h4b5e);
      $display("payload formats done");
      for (int i = 0; i < 3; i++) begin
         ca <= 9'h005;
         cb <= 9'h005;
         cfg(fm[i], 6'd16, 1'b1);
         ca <= 9'h101;
         cb <= 9'h000;
         waitf(2);
         chk(40'({stp, dir}), 40'(ep[i]));
         chk(40'(p.prev[7:0]), 40'(ea[i]));
         chk(40'(p.word[7:0]), 40'(eb[i]));
      end
      $display("dac formats done");
      cfg(4'hf, 6'd32, 1'b0);
      repeat (1500) @(posedge clk);
      rreg(STS, 32'ha5c3_0f96);
      rreg(10'h1b4, 32'h0f96_9696);
      cfg(4'hf, 6'd32, 1'b1);
      waitf(0);
      $display("polling done");
      end_sim;
   end
   // Watchdog: over four times the expected run
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      end_sim;
   end
endmodule
`default_nettype wire
